// *** shared/cic_cfg.svh ***
`ifndef CIC_CFG_SVH
`define CIC_CFG_SVH

// register byte addresses
`define CIC_ADDR_CTRL    8'h00
`define CIC_ADDR_RXFLG   8'h04
`define CIC_ADDR_RXIE    8'h08
`define CIC_ADDR_TXFLG   8'h0c
`define CIC_ADDR_TXIE    8'h10
`define CIC_ADDR_ERRCNT  8'h14
`define CIC_ADDR_CFG     8'h18
`define CIC_ADDR_CFG_END 8'h40

// protected configuration bank, byte count and index of three of its bytes
`define CIC_CFG_NUM      11
`define CIC_IDX_MCTRL2   4'h0
`define CIC_IDX_CODE1    4'h5
`define CIC_IDX_MASK1    4'h9

// control register fields and reset value
`define CIC_CTRL_LOCK    0
`define CIC_CTRL_SLEEPRQ 1
`define CIC_CTRL_RST     8'h01

// flag vector positions: rx flag register low, tx flags above
`define CIC_F_RXFULL     0
`define CIC_F_OVR        1
`define CIC_F_BOFF       2
`define CIC_F_TPASS      3
`define CIC_F_RPASS      4
`define CIC_F_TWARN      5
`define CIC_F_RWARN      6
`define CIC_F_WAKE       7
`define CIC_F_TX0        8
`define CIC_NFLAG        11
`define CIC_FLAG_RST     11'h700
`define CIC_ERR_MASK     11'h07e

// error counter limits
`define CIC_WARN_LIMIT   8'h60
`define CIC_PASS_LIMIT   8'h7f
`define CIC_BOFF_LIMIT   9'h0ff

// bus answers and pin level
`define CIC_RESP_OKAY    2'h0
`define CIC_RESP_SLVERR  2'h2
`define CIC_RECESSIVE    1'h1

`endif

// *** shared/cic_pkg.sv ***
package cic_pkg;

	// controller operating mode
	typedef enum logic [2:0] {
		CIC_ST_NORMAL = 3'b001,
		CIC_ST_SLEEP  = 3'b010,
		CIC_ST_SOFT   = 3'b100
	} cic_mode_type;

	// status coming from the protocol engine
	typedef struct packed {
		logic       rx_frame_ok;
		logic       rx_overrun;
		logic       bus_activity;
		logic       engine_idle;
		logic [7:0] rx_err_cnt;
		logic [8:0] tx_err_cnt;
		logic [2:0] tx_done;
		logic       tx_bit;
		logic [7:0] shift_byte;
		logic [7:0] shift_byte_early;
		logic       stuff_16_15;
	} cic_eng_type;

	// the four interrupt request lines
	typedef struct packed {
		logic wakeup;
		logic error;
		logic receive;
		logic transmit;
	} cic_irq_type;

endpackage : cic_pkg

// *** hdl/cic_flag.sv ***
`timescale 1ns/100ps
module cic_flag #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	// set and write-one clear
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);
	import cic_pkg::*;

	logic next_q;

	// set beats clear, so a live condition keeps the flag up
	assign next_q = set | (q & ~clr);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= RST_VAL;
		else if (ce)
			q <= next_q;
	end

	AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && set) |=> q) else $error("flag lost a set");
endmodule : cic_flag

// *** hdl/cic_top.sv ***
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "cic_cfg.svh"

// Notes on behaviour
// - four vectors from eleven sources, each source with its own enable bit.
// - each empty transmit buffer flags itself; each buffer has its own enable.
// - receive-full flag set right after end of frame into the foreground buffer.
// - wakeup flag only on bus activity while sleep ack and wakeup enable are 1.
// - receive overrun sets overrun flag, an error source.
// - receive error count reaching 96 sets receive warning flag.
// - transmit error count reaching 96 sets transmit warning flag.
// - receive error count above 127 sets receive error-passive flag.
// - transmit error count above 127 sets transmit error-passive flag.
// - transmit error count above 255 sets bus-off flag.
// - interrupt stays pending while any of its flags remains set.
// - software clears a flag only by writing one to its bit.
// - clearing is ignored while the setting condition still holds.
// - wakeup, six error, receive, three transmit flags; all gated by global mask.
// - error counters cannot be written by software.
// - configuration bank writes take effect only while soft reset lock is set.
// - transmit pin forced recessive in every low-power mode.
// - byte-two compare uses early shift contents after a stuff bit at 16/15.
// - setting soft reset halts transmission and reception at once.
// - sleep acknowledge stays set for the whole sleep period.
module cic_top (
	// clock, reset, enable
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ce,
	// axi4-lite write
	input  wire logic [7:0]            awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	// axi4-lite read
	input  wire logic [7:0]            araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	// protocol engine side
	input  wire cic_pkg::cic_eng_type  eng,
	input  wire logic                  power_down,
	output logic                       engine_halt,
	output logic                       can_transmit_pin,
	output logic [10:0][7:0]           config_regs,
	output logic                       byte_two_match,
	// cpu interrupt side
	input  wire logic                  global_mask,
	output cic_pkg::cic_irq_type       irq
);
	import cic_pkg::*;

	////////////////////////////////////////////////////////////////////
	// state
	logic              aw_held;
	logic              w_held;
	logic [7:0]        aw_addr;
	logic [7:0]        w_data;
	logic              w_strb0;
	logic [7:0]        ctrl;
	logic [7:0]        rx_ie;
	logic [2:0]        tx_ie;
	cic_mode_type      mode;
	cic_mode_type      next_mode;
	logic [10:0]       flags;
	logic [10:0]       flag_set;
	logic [10:0]       flag_clr;
	logic [10:0]       flag_en;

	////////////////////////////////////////////////////////////////////
	// write decode
	wire        do_write  = ce & aw_held & w_held & ~bvalid;
	wire        wr_go     = do_write & w_strb0;
	wire [7:0]  wa_off    = aw_addr - `CIC_ADDR_CFG;
	wire [3:0]  wa_idx    = wa_off[5:2];
	wire        wa_cfg    = (aw_addr >= `CIC_ADDR_CFG) & (aw_addr <= `CIC_ADDR_CFG_END);
	wire        wa_known  = (aw_addr <= `CIC_ADDR_CFG_END) & (aw_addr[1:0] == 2'h0);
	wire        wr_ctrl   = wr_go & (aw_addr == `CIC_ADDR_CTRL);
	wire        wr_rxflg  = wr_go & (aw_addr == `CIC_ADDR_RXFLG);
	wire        wr_rxie   = wr_go & (aw_addr == `CIC_ADDR_RXIE);
	wire        wr_txflg  = wr_go & (aw_addr == `CIC_ADDR_TXFLG);
	wire        wr_txie   = wr_go & (aw_addr == `CIC_ADDR_TXIE);
	wire        lock      = ctrl[`CIC_CTRL_LOCK];
	wire        sleep_req = ctrl[`CIC_CTRL_SLEEPRQ];
	wire        wr_cfg    = wr_go & wa_cfg & wa_known & lock;

	// handshake readies drop with ce so nothing is taken while frozen
	assign awready = ce & ~aw_held;
	assign wready  = ce & ~w_held;
	assign arready = ce & ~rvalid;

	// address and data are captured in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (ce && awvalid && !aw_held) begin
			aw_held <= 1'b1;
			aw_addr <= awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held  <= 1'b0;
			w_data  <= 8'h00;
			w_strb0 <= 1'b0;
		end else if (ce && wvalid && !w_held) begin
			w_held  <= 1'b1;
			w_data  <= wdata[7:0];
			w_strb0 <= wstrb[0];
		end else if (do_write) begin
			w_held  <= 1'b0;
		end
	end

	// response follows both halves; unmapped addresses get slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `CIC_RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wa_known ? `CIC_RESP_OKAY : `CIC_RESP_SLVERR;
		end else if (ce && bready) begin
			bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// software registers
	// counters sit outside this bank, so a write can never reach them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl  <= `CIC_CTRL_RST;
			rx_ie <= 8'h00;
			tx_ie <= 3'h0;
		end else begin
			if (wr_ctrl)
				ctrl <= w_data;
			if (wr_rxie)
				rx_ie <= w_data;
			if (wr_txie)
				tx_ie <= w_data[2:0];
		end
	end

	// configuration bank only moves while the lock is set
	always_ff @(posedge aclk) begin
		if (!aresetn)
			config_regs <= '0;
		else if (wr_cfg)
			config_regs[wa_idx] <= w_data;
	end

	////////////////////////////////////////////////////////////////////
	// read path
	wire [7:0]  ra_off   = araddr - `CIC_ADDR_CFG;
	wire [3:0]  ra_idx   = ra_off[5:2];
	wire        ra_known = (araddr <= `CIC_ADDR_CFG_END) & (araddr[1:0] == 2'h0);
	wire        ra_cfg   = araddr >= `CIC_ADDR_CFG;
	wire [31:0] ra_cnt   = {15'h0000, eng.tx_err_cnt, eng.rx_err_cnt};
	wire [31:0] rd_mux   =
		!ra_known                      ? 32'h0000_0000 :
		ra_cfg                         ? {24'h000000, config_regs[ra_idx]} :
		(araddr == `CIC_ADDR_CTRL)     ? {24'h000000, ctrl} :
		(araddr == `CIC_ADDR_RXFLG)    ? {24'h000000, flags[7:0]} :
		(araddr == `CIC_ADDR_RXIE)     ? {24'h000000, rx_ie} :
		(araddr == `CIC_ADDR_TXFLG)    ? {29'h00000000, flags[10:8]} :
		(araddr == `CIC_ADDR_TXIE)     ? {29'h00000000, tx_ie} :
		ra_cnt;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `CIC_RESP_OKAY;
		end else if (ce && arvalid && !rvalid) begin
			rvalid <= 1'b1;
			rdata  <= rd_mux;
			rresp  <= ra_known ? `CIC_RESP_OKAY : `CIC_RESP_SLVERR;
		end else if (ce && rready) begin
			rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode control: sleep needs an idle engine, lock overrides all
	wire sleep_ack = (mode == CIC_ST_SLEEP);

	always_comb begin
		next_mode = mode;
		unique case (mode)
			CIC_ST_NORMAL: begin
				if (lock)
					next_mode = CIC_ST_SOFT;
				else if (sleep_req && eng.engine_idle)
					next_mode = CIC_ST_SLEEP;
			end
			CIC_ST_SLEEP: begin
				if (lock)
					next_mode = CIC_ST_SOFT;
				else if (!sleep_req || eng.bus_activity)
					next_mode = CIC_ST_NORMAL;
			end
			CIC_ST_SOFT: begin
				if (!lock)
					next_mode = CIC_ST_NORMAL;
			end
			default: next_mode = CIC_ST_SOFT;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mode <= CIC_ST_SOFT;
		else if (ce)
			mode <= next_mode;
	end

	// halt follows the lock bit directly, even mid-frame
	assign engine_halt = lock;

	// any low-power mode pins the line recessive
	assign can_transmit_pin = (mode != CIC_ST_NORMAL || power_down) ?
		`CIC_RECESSIVE : eng.tx_bit;

	////////////////////////////////////////////////////////////////////
	// flag sources; level conditions keep setting, which blocks a clear
	wire rwarn_c = eng.rx_err_cnt >= `CIC_WARN_LIMIT;
	wire twarn_c = eng.tx_err_cnt >= {1'b0, `CIC_WARN_LIMIT};
	wire rpass_c = eng.rx_err_cnt > `CIC_PASS_LIMIT;
	wire tpass_c = eng.tx_err_cnt > {1'b0, `CIC_PASS_LIMIT};
	wire boff_c  = eng.tx_err_cnt > `CIC_BOFF_LIMIT;
	wire wake_c  = eng.bus_activity & (sleep_ack | power_down) & sleep_ack
		& rx_ie[`CIC_F_WAKE];

	// new frame lands in the foreground only while it is free
	assign flag_set[`CIC_F_RXFULL] = eng.rx_frame_ok & ~flags[`CIC_F_RXFULL];
	assign flag_set[`CIC_F_OVR]    = eng.rx_overrun;
	assign flag_set[`CIC_F_BOFF]   = boff_c;
	assign flag_set[`CIC_F_TPASS]  = tpass_c;
	assign flag_set[`CIC_F_RPASS]  = rpass_c;
	assign flag_set[`CIC_F_TWARN]  = twarn_c;
	assign flag_set[`CIC_F_RWARN]  = rwarn_c;
	assign flag_set[`CIC_F_WAKE]   = wake_c;
	assign flag_set[10:8]          = eng.tx_done;

	// write one clears; zeros leave flags alone
	assign flag_clr = {wr_txflg ? w_data[2:0] : 3'h0,
		wr_rxflg ? w_data : 8'h00};

	genvar gi;
	generate
		for (gi = 0; gi < `CIC_NFLAG; gi++) begin : g_flag
			cic_flag #(
				.RST_VAL (1'((`CIC_FLAG_RST >> gi) & 1))
			) u_flag (
				.aclk    (aclk),
				.aresetn (aresetn),
				.ce      (ce),
				.set     (flag_set[gi]),
				.clr     (flag_clr[gi]),
				.q       (flags[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// vectors: flag and enable, ored per group, then cpu mask
	assign flag_en      = flags & {tx_ie, rx_ie};
	assign irq.wakeup   = flag_en[`CIC_F_WAKE] & ~global_mask;
	assign irq.error    = |(flag_en & `CIC_ERR_MASK) & ~global_mask;
	assign irq.receive  = flag_en[`CIC_F_RXFULL] & ~global_mask;
	assign irq.transmit = |flag_en[10:8] & ~global_mask;

	////////////////////////////////////////////////////////////////////
	// byte-two filter compare keeps the early-shift quirk; masked bits
	// are don't care, which is how 1111 xxx1 hides it
	wire [7:0] cmp_val = eng.stuff_16_15 ? eng.shift_byte_early : eng.shift_byte;
	wire       cmp_hit = ((cmp_val ^ config_regs[`CIC_IDX_CODE1])
		& ~config_regs[`CIC_IDX_MASK1]) == 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			byte_two_match <= 1'b0;
		else if (ce)
			byte_two_match <= cmp_hit;
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_sleep_entry;
		ce && mode == CIC_ST_NORMAL && !lock && sleep_req && eng.engine_idle;
	endsequence

	AST_RWARN: assert property (ce && rwarn_c |=> flags[`CIC_F_RWARN])
		else $error("rx warning not set");
	AST_TWARN: assert property (ce && twarn_c |=> flags[`CIC_F_TWARN])
		else $error("tx warning not set");
	AST_RPASS: assert property (ce && rpass_c && flag_clr[`CIC_F_RPASS]
		|=> flags[`CIC_F_RPASS])
		else $error("rx passive cleared while live");
	AST_TPASS: assert property (ce && tpass_c |=> flags[`CIC_F_TPASS])
		else $error("tx passive not set");
	AST_BOFF: assert property ($rose(flags[`CIC_F_BOFF])
		|-> $past(eng.tx_err_cnt) > `CIC_BOFF_LIMIT)
		else $error("bus off without cause");
	AST_WAKE: assert property ($rose(flags[`CIC_F_WAKE])
		|-> $past(sleep_ack && rx_ie[`CIC_F_WAKE]))
		else $error("wakeup outside sleep");
	AST_RXFULL: assert property (ce && eng.rx_frame_ok
		|=> flags[`CIC_F_RXFULL])
		else $error("receive full missing");
	AST_OVR: assert property (ce && eng.rx_overrun ##1 1 |-> flags[`CIC_F_OVR])
		else $error("overrun missing");
	AST_LOCK: assert property (do_write && wa_cfg && !lock
		|=> $stable(config_regs))
		else $error("config changed unlocked");
	AST_TXPIN: assert property (mode != CIC_ST_NORMAL
		|-> can_transmit_pin == `CIC_RECESSIVE)
		else $error("pin not recessive");
	AST_SLEEP: assert property (s_sleep_entry |=> sleep_ack)
		else $error("sleep ack late");
	AST_ERRV: assert property (irq.error
		== (|(flags & {tx_ie, rx_ie} & `CIC_ERR_MASK) && !global_mask))
		else $error("error vector wrong");
endmodule : cic_top

// *** testbench/cic_eng_model.sv ***
`timescale 1ns/100ps
module cic_eng_model
	import cic_pkg::*;
(
	// clock and halt from the block
	input  wire logic          aclk,
	input  wire logic          engine_halt,
	// status toward the block
	output cic_pkg::cic_eng_type eng
);
	import cic_pkg::*;

	logic [7:0] rxc = 8'h00;
	logic [8:0] txc = 9'h000;
	logic       act = 1'b0;
	logic       tb  = 1'b0;
	logic [4:0] pls = 5'h00;
	logic       stf = 1'b0; // stuff bit between 16 and 15 seen

	////////////////////////////////////////////////////////////////////////////////
	// tx bit toggles every cycle so a pin stuck at one level shows up
	always_ff @(posedge aclk) begin
		tb <= ~tb;
	end

	// frame events last one cycle; a halted engine reports none
	task automatic pulse(input logic [4:0] p);
		@(posedge aclk);
		pls <= engine_halt ? 5'h00 : p;
		@(posedge aclk);
		pls <= 5'h00;
	endtask : pulse

	////////////////////////////////////////////////////////////////////////////////
	// packed status, pulses as {frame ok, overrun, tx done[2:0]}
	assign eng = '{rx_frame_ok: pls[4], rx_overrun: pls[3], bus_activity: act,
		engine_idle: 1'b1, rx_err_cnt: rxc, tx_err_cnt: txc, tx_done: pls[2:0],
		tx_bit: tb, shift_byte: 8'ha5, shift_byte_early: 8'h52, stuff_16_15: stf};
endmodule : cic_eng_model

// *** testbench/can_interrupt_and_protection_test.sv ***
`timescale 1ns/100ps
`include "cic_cfg.svh"
module can_interrupt_and_protection_test;
	import cic_pkg::*;

	// clock, reset and bus
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [7:0]        awaddr = 8'h00;
	logic [7:0]        araddr = 8'h00;
	logic [31:0]       wdata = 32'h0;
	logic              awvalid = 1'b0;
	logic              wvalid = 1'b0;
	logic              bready = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready = 1'b0;
	logic              power_down = 1'b0;
	logic              global_mask = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic              engine_halt, can_transmit_pin, byte_two_match;
	logic [1:0]        bresp, rresp, r;
	logic [31:0]       rdata, d;
	logic [10:0][7:0]  config_regs;
	cic_eng_type       eng;
	cic_irq_type       irq;
	int                miscompares = 0;
	int                cmp_count = 0;

	always #20 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////////
	cic_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .eng(eng),
		.power_down(power_down), .engine_halt(engine_halt),
		.can_transmit_pin(can_transmit_pin), .config_regs(config_regs),
		.byte_two_match(byte_two_match), .global_mask(global_mask), .irq(irq));
	cic_eng_model i_eng (.aclk(aclk), .engine_halt(engine_halt), .eng(eng));

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// readiness is looked at on the falling edge, so it has settled by the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int   n;
		logic ta, tw, tb;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid & bready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			n++;
			if (n > 200) begin
				miscompares++;
				conclude();
			end
		end while (!tb);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
		int   n;
		logic ta, tr;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid & arready;
			tr = rvalid & rready;
			v = rdata;
			e = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
			n++;
			if (n > 200) begin
				miscompares++;
				conclude();
			end
		end while (!tr);
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, d, r);
		chk(d, exp);
	endtask : rdchk

	task automatic irqchk(input logic [3:0] exp);
		@(negedge aclk);
		chk({28'h0, irq}, {28'h0, exp});
	endtask : irqchk

	////////////////////////////////////////////////////////////////////////////////
	// reset state and configuration lock
	task automatic t_lock;
		rdchk(`CIC_ADDR_CTRL, {24'h0, `CIC_CTRL_RST});
		rdchk(`CIC_ADDR_TXFLG, 32'h7);
		rdchk(`CIC_ADDR_RXFLG, 32'h0);
		irqchk(4'h0);
		chk(can_transmit_pin, `CIC_RECESSIVE);
		chk(engine_halt, 1'b1);
		wr(`CIC_ADDR_CFG, 32'h5a);
		wr(`CIC_ADDR_CFG + 8'h04, 32'h44);
		wr(`CIC_ADDR_CFG + 8'h24, 32'hf1);
		wr(`CIC_ADDR_CFG + 8'h14, 32'ha5);
		wr(`CIC_ADDR_CTRL, 32'h0);
		chk(engine_halt, 1'b0);
		wr(`CIC_ADDR_CFG + 8'h04, 32'h33);
		chk(config_regs[0], 8'h5a);
		chk(config_regs[`CIC_IDX_MASK1], 8'hf1);
		chk(config_regs[1], 8'h44);
		@(negedge aclk);
		chk(can_transmit_pin, eng.tx_bit);
		chk(byte_two_match, 1'b1);
		i_eng.stf <= 1'b1;
		repeat (2) @(negedge aclk);
		chk(byte_two_match, 1'b0);
		i_eng.stf <= 1'b0;
		i_eng.rxc <= 8'h11;
		i_eng.txc <= 9'h022;
		wr(`CIC_ADDR_ERRCNT, 32'hffffffff);
		rdchk(`CIC_ADDR_ERRCNT, 32'h2211);
		rd(8'h80, d, r);
		chk(r, `CIC_RESP_SLVERR);
		chk(d, 32'h0);
	endtask : t_lock

	// transmit vector: per-buffer enable, global mask, one-to-clear
	task automatic t_tx;
		wr(`CIC_ADDR_TXIE, 32'h7);
		irqchk(4'h1);
		global_mask <= 1'b1;
		irqchk(4'h0);
		global_mask <= 1'b0;
		wr(`CIC_ADDR_TXFLG, 32'h7);
		rdchk(`CIC_ADDR_TXFLG, 32'h0);
		irqchk(4'h0);
		i_eng.pulse(5'h02);
		rdchk(`CIC_ADDR_TXFLG, 32'h2);
		irqchk(4'h1);
		wr(`CIC_ADDR_TXIE, 32'h5);
		irqchk(4'h0);
		wr(`CIC_ADDR_TXFLG, 32'h2);
		wr(`CIC_ADDR_TXIE, 32'h0);
	endtask : t_tx

	// error counter limits, clear refused while the condition holds
	task automatic t_err;
		logic [7:0] rt [6];
		logic [8:0] tt [6];
		logic [7:0] ft [6];
		rt = '{8'h5f, 8'h60, 8'h80, 8'h80, 8'h80, 8'h80};
		tt = '{9'h05f, 9'h000, 9'h000, 9'h060, 9'h080, 9'h100};
		ft = '{8'h00, 8'h40, 8'h50, 8'h70, 8'h78, 8'h7c};
		for (int i = 0; i < 6; i++) begin
			i_eng.rxc <= rt[i];
			i_eng.txc <= tt[i];
			repeat (2) @(posedge aclk);
			rdchk(`CIC_ADDR_RXFLG, {24'h0, ft[i]});
		end
		wr(`CIC_ADDR_RXIE, 32'h7e);
		irqchk(4'h4);
		wr(`CIC_ADDR_RXFLG, 32'h7c);
		rdchk(`CIC_ADDR_RXFLG, 32'h7c);
		i_eng.rxc <= 8'h00;
		i_eng.txc <= 9'h000;
		wr(`CIC_ADDR_RXFLG, 32'h04);
		rdchk(`CIC_ADDR_RXFLG, 32'h78);
		irqchk(4'h4);
		wr(`CIC_ADDR_RXFLG, 32'h78);
		irqchk(4'h0);
	endtask : t_err

	// receive full and overrun
	task automatic t_rx;
		i_eng.pulse(5'h10);
		rdchk(`CIC_ADDR_RXFLG, 32'h01);
		wr(`CIC_ADDR_RXIE, 32'h01);
		irqchk(4'h2);
		i_eng.pulse(5'h08);
		rdchk(`CIC_ADDR_RXFLG, 32'h03);
		irqchk(4'h2);
		wr(`CIC_ADDR_RXIE, 32'h03);
		irqchk(4'h6);
		wr(`CIC_ADDR_RXFLG, 32'h03);
		wr(`CIC_ADDR_RXIE, 32'h80);
	endtask : t_rx

	// wakeup only from sleep; pin recessive in sleep and power down
	task automatic t_wake;
		i_eng.act <= 1'b1;
		repeat (3) @(posedge aclk);
		i_eng.act <= 1'b0;
		rdchk(`CIC_ADDR_RXFLG, 32'h0);
		wr(`CIC_ADDR_CTRL, 32'h2);
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk(can_transmit_pin, `CIC_RECESSIVE);
		@(posedge aclk);
		i_eng.act <= 1'b1;
		repeat (2) @(posedge aclk);
		i_eng.act <= 1'b0;
		rdchk(`CIC_ADDR_RXFLG, 32'h80);
		irqchk(4'h8);
		wr(`CIC_ADDR_CTRL, 32'h0);
		wr(`CIC_ADDR_RXFLG, 32'h80);
		irqchk(4'h0);
		power_down <= 1'b1;
		@(negedge aclk);
		chk(can_transmit_pin, `CIC_RECESSIVE);
		power_down <= 1'b0;
	endtask : t_wake

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_lock();
		t_tx();
		t_err();
		t_rx();
		t_wake();
		conclude();
	end
endmodule : can_interrupt_and_protection_test
